// *** diag_adc_defines.vh ***
// register indices, field positions, reset values and channel codes of the diagnostic block
`ifndef DIAG_ADC_DEFINES_VH
`define DIAG_ADC_DEFINES_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_LIMIT_FLAGS      8'h23
`define IDX_EXT_A_RESULT     8'h24
`define IDX_EXT_B_RESULT     8'h25
`define IDX_TEMP_RESULT      8'h26
`define IDX_SD_MUX_RESULT    8'h27
`define IDX_CMP_OFFSET       8'h28
`define IDX_DAC_APPLIED      8'h2c
`define IDX_RAW_RESULT       8'h2d
`define IDX_BYPASS_CTRL      8'h2e
`define IDX_IRQ_STATUS       8'h30
`define IDX_IRQ_MASK         8'h31

// ----------------------------------------------------------------------------
// bypass control fields
// ----------------------------------------------------------------------------
`define BYP_RESULT_EN_BIT    15
`define BYP_OFFSET_EN_BIT    14
`define BYP_GND_DIS_BIT      13
`define BYP_RSVD_BIT         12
`define BYP_RESET            16'h0000
`define BYP_WR_MASK          16'hefff

// ----------------------------------------------------------------------------
// result fields and reset values
// ----------------------------------------------------------------------------
`define RES_MSB              11
`define RES_RESET            12'h000
`define RES_MAX              12'hfff
`define DAC_RESET            16'h0000
`define FLAG_LSB             1

// ----------------------------------------------------------------------------
// channel codes
// ----------------------------------------------------------------------------
`define CH_EXT_A             3'h0
`define CH_EXT_B             3'h1
`define CH_TEMP              3'h2
`define CH_SD_FIRST          3'h3

// ----------------------------------------------------------------------------
// interrupt status bits and timing
// ----------------------------------------------------------------------------
`define IRQ_CONV_BIT         0
`define IRQ_FAIL_BIT         1
`define IRQ_RESET            2'h0
`define GND_PHASE_CYCLES     4'h2

`endif

// *** diag_adc_result_bypass.v ***
// diagnostic adc readback, limit flags and bypass control behind an ahb-lite slave
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "diag_adc_defines.vh"

// Behaviour
// [RL1] eight read-only limit flags, bits eight to one
// [RL2] external inputs each give a 12-bit result
// [RL3] temperature result held in low twelve bits
// [RL4] self-diagnostic mux result in low twelve bits
// [RL5] measured offset readable and adjusts each result
// [RL6] offset override uses bypass data as offset
// [RL7] offset readback always shows measured value
// [RL8] read-only applied dac code, sixteen bits
// [RL9] raw result per conversion, no offset, no bypass
// [RL10] data bypass substitutes bypass data for result
// [RL11] bypass value stored and limit-checked per channel
// [RL12] data bypass wins over offset override
// [RL13] software never sets both enables together
// [RL14] override offset read as two's complement
// [RL15] ground sampling phase unless bit thirteen set
// [RL16] bypass control resets zero, bit twelve reserved
// [RL17] flag set when result outside channel thresholds
module diag_adc_result_bypass #(
  parameter NUM_CH     = 8,
  parameter RES_W      = 12,
  parameter GND_CYCLES = 4
) (
  input  wire                   mclk,               // system clock, 20 MHz
  input  wire                   sys_rst,            // synchronous reset, active high
  input  wire                   hsel,               // ahb slave select
  input  wire [31:0]            haddr,              // ahb address
  input  wire [1:0]             htrans,             // ahb transfer type
  input  wire                   hwrite,             // ahb write strobe
  input  wire [2:0]             hsize,              // ahb size, word only
  input  wire                   hready,             // ahb bus ready
  input  wire [31:0]            hwdata,             // ahb write data
  output reg  [31:0]            hrdata,             // ahb read data
  output wire                   hreadyout,          // ahb slave ready
  output wire                   hresp,              // ahb response, always okay
  input  wire                   conv_start,         // request a sampling sequence
  output wire                   gnd_sample,         // ground sampling phase active
  output wire                   sig_sample,         // signal sampling strobe
  input  wire                   conv_valid,         // conversion finished, one cycle
  input  wire [2:0]             conv_channel,       // channel just converted
  input  wire [RES_W-1:0]       conv_raw,           // raw comparator result
  input  wire                   meas_offset_valid,  // new offset measurement
  input  wire [RES_W-1:0]       meas_offset,        // measured offset, signed
  input  wire [15:0]            dac_applied,        // code now on the analog path
  input  wire [NUM_CH*RES_W-1:0] lo_thresholds,     // low limit per channel
  input  wire [NUM_CH*RES_W-1:0] hi_thresholds,     // high limit per channel
  output wire                   irq                 // level interrupt
);

  // --------------------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_GND  = 3'h2;
  localparam [2:0] ST_SIG  = 3'h4;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  reg  [15:0]        bypass_r;
  reg  [15:0]        bypass_nxt;
  reg  [1:0]         irq_status_r;
  reg  [1:0]         irq_status_nxt;
  reg  [1:0]         irq_mask_r;
  reg  [1:0]         irq_mask_nxt;
  reg  [RES_W-1:0]   ext_a_r;
  reg  [RES_W-1:0]   ext_b_r;
  reg  [RES_W-1:0]   temp_r;
  reg  [RES_W-1:0]   sd_mux_r;
  reg  [RES_W-1:0]   offset_r;
  reg  [RES_W-1:0]   raw_r;
  reg  [15:0]        dac_r;
  reg  [NUM_CH-1:0]  flags_r;
  reg  [2:0]         state_r;
  reg  [2:0]         state_nxt;
  reg  [3:0]         gnd_cnt_r;
  reg  [3:0]         gnd_cnt_nxt;
  reg                wr_pend_r;
  reg  [7:0]         wr_idx_r;
  reg  [15:0]        rd_val;
  reg  [RES_W-1:0]   adj_off;
  reg  [RES_W-1:0]   result;
  wire [RES_W+1:0]   diff;
  wire [NUM_CH-1:0]  fail_now;
  wire [NUM_CH-1:0]  hit_ch;
  wire               addr_phase;
  wire [7:0]         addr_idx;
  wire               result_en;
  wire               offset_en;
  wire               gnd_en;
  wire               wr_now;
  wire               wr_byp;
  wire               wr_status;
  wire               wr_mask;
  wire               below_zero;
  wire               above_max;
  wire [RES_W+1:0]   raw_ext;
  wire [RES_W+1:0]   off_ext;
  wire [15:0]        flags_word;
  wire [15:0]        ext_a_word;
  wire [15:0]        ext_b_word;
  wire [15:0]        temp_word;
  wire [15:0]        sd_mux_word;
  wire [15:0]        offset_word;
  wire [15:0]        dac_word;
  wire [15:0]        raw_word;
  wire [15:0]        bypass_word;
  wire [15:0]        status_word;
  wire [15:0]        mask_word;
  reg                irq_r;

  // --------------------------------------------------------------------------
  // ahb response
  // --------------------------------------------------------------------------
  // every register answers in its data phase, so no wait state is needed
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // --------------------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------------------
  assign result_en = bypass_r[`BYP_RESULT_EN_BIT];
  assign offset_en = bypass_r[`BYP_OFFSET_EN_BIT];
  assign gnd_en    = ~bypass_r[`BYP_GND_DIS_BIT];

  // --------------------------------------------------------------------------
  // ahb address phase
  // --------------------------------------------------------------------------
  // zero wait states; reads sample the next value so a read right after a
  // write sees the written data
  // hsize and byte lanes are not decoded: software must use word accesses
  assign addr_phase = hsel & hready & htrans[1];
  assign addr_idx   = haddr[9:2];
  assign wr_now     = wr_pend_r;

  always @(posedge mclk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= addr_phase & hwrite;
      wr_idx_r  <= addr_idx;
    end
  end

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  // decodes the index latched in the address phase, not the live bus,
  // so a new address phase cannot redirect a data phase in flight
  assign wr_byp    = wr_now & (wr_idx_r == `IDX_BYPASS_CTRL);
  assign wr_status = wr_now & (wr_idx_r == `IDX_IRQ_STATUS);
  assign wr_mask   = wr_now & (wr_idx_r == `IDX_IRQ_MASK);

  // --------------------------------------------------------------------------
  // writable registers
  // --------------------------------------------------------------------------
  always @* begin
    bypass_nxt = bypass_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_byp)
      bypass_nxt = hwdata[15:0] & `BYP_WR_MASK; // [RL16]
    if (wr_mask)
      irq_mask_nxt = hwdata[1:0];
  end

  // events set, write-one clears; a set in the same cycle wins
  always @* begin
    irq_status_nxt = irq_status_r;
    if (wr_status)
      irq_status_nxt = irq_status_r & ~hwdata[1:0];
    if (conv_valid)
      irq_status_nxt[`IRQ_CONV_BIT] = 1'b1;
    if (conv_valid && |(fail_now & hit_ch))
      irq_status_nxt[`IRQ_FAIL_BIT] = 1'b1;
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      bypass_r     <= `BYP_RESET; // [RL16]
      irq_mask_r   <= `IRQ_RESET;
      irq_status_r <= `IRQ_RESET;
    end else begin
      bypass_r     <= bypass_nxt;
      irq_mask_r   <= irq_mask_nxt;
      irq_status_r <= irq_status_nxt;
    end
  end

  // registered so the pin cannot glitch while status and mask settle
  always @(posedge mclk) begin
    if (sys_rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_status_nxt & irq_mask_nxt);
  end

  assign irq = irq_r;

  // --------------------------------------------------------------------------
  // result adjustment
  // --------------------------------------------------------------------------
  always @* begin
    if (offset_en)
      adj_off = bypass_r[`RES_MSB:0]; // [RL6] [RL14]
    else
      adj_off = offset_r; // [RL5]
  end

  // signed subtract with clamp into the unsigned result range; two guard
  // bits keep the worst case of both extremes from wrapping
  assign raw_ext    = {2'b00, conv_raw};
  assign off_ext    = {{2{adj_off[RES_W-1]}}, adj_off};
  assign diff       = raw_ext - off_ext;
  assign below_zero = diff[RES_W+1];
  assign above_max  = diff[RES_W];

  always @* begin
    if (result_en)
      result = bypass_r[`RES_MSB:0]; // [RL10] [RL12]
    else if (below_zero)
      result = `RES_RESET; // [RL5]
    else if (above_max)
      result = `RES_MAX;
    else
      result = diff[RES_W-1:0];
  end

  // --------------------------------------------------------------------------
  // per-channel limit flags
  // --------------------------------------------------------------------------
  // flags of channels not converted keep their last verdict
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
      localparam [2:0] CH = i;
      wire [RES_W-1:0] lo = lo_thresholds[i*RES_W +: RES_W];
      wire [RES_W-1:0] hi = hi_thresholds[i*RES_W +: RES_W];
      assign hit_ch[i]   = (conv_channel == CH);
      assign fail_now[i] = (result < lo) | (result > hi); // [RL17]
      always @(posedge mclk) begin
        if (sys_rst)
          flags_r[i] <= 1'b0;
        else if (conv_valid && hit_ch[i])
          flags_r[i] <= fail_now[i]; // [RL11] [RL17]
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // result, offset, raw and dac readback registers
  // --------------------------------------------------------------------------
  // the raw code skips both the offset and the data override
  always @(posedge mclk) begin
    if (sys_rst) begin
      ext_a_r  <= `RES_RESET;
      ext_b_r  <= `RES_RESET;
      temp_r   <= `RES_RESET;
      sd_mux_r <= `RES_RESET;
      raw_r    <= `RES_RESET;
    end else if (conv_valid) begin
      raw_r <= conv_raw; // [RL9]
      case (conv_channel)
        `CH_EXT_A: ext_a_r <= result; // [RL2] [RL11]
        `CH_EXT_B: ext_b_r <= result; // [RL2] [RL11]
        `CH_TEMP:  temp_r  <= result; // [RL3] [RL11]
        default:   sd_mux_r <= result; // [RL4] [RL11]
      endcase
    end
  end

  // offset readback never looks at the bypass register
  always @(posedge mclk) begin
    if (sys_rst)
      offset_r <= `RES_RESET;
    else if (meas_offset_valid)
      offset_r <= meas_offset; // [RL7]
  end

  always @(posedge mclk) begin
    if (sys_rst)
      dac_r <= `DAC_RESET;
    else
      dac_r <= dac_applied; // [RL8]
  end

  // --------------------------------------------------------------------------
  // sampling sequencer
  // --------------------------------------------------------------------------
  // the ground phase discharges the sampling cap to limit crosstalk
  // a start request while a sequence runs is dropped
  always @* begin
    state_nxt   = state_r;
    gnd_cnt_nxt = gnd_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (conv_start) begin
          gnd_cnt_nxt = GND_CYCLES[3:0] - 4'h1;
          if (gnd_en)
            state_nxt = ST_GND; // [RL15]
          else
            state_nxt = ST_SIG; // [RL15]
        end
      end
      ST_GND: begin
        if (gnd_cnt_r == 4'h0)
          state_nxt = ST_SIG;
        else
          gnd_cnt_nxt = gnd_cnt_r - 4'h1;
      end
      ST_SIG: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      gnd_cnt_r <= 4'h0;
    end else begin
      state_r   <= state_nxt;
      gnd_cnt_r <= gnd_cnt_nxt;
    end
  end

  assign gnd_sample = (state_r == ST_GND);
  assign sig_sample = (state_r == ST_SIG);

  // --------------------------------------------------------------------------
  // readback words
  // --------------------------------------------------------------------------
  // reserved bits are tied low here so every read of them returns zero
  assign flags_word  = {7'h00, flags_r, 1'b0}; // [RL1]
  assign ext_a_word  = {4'h0, ext_a_r}; // [RL2]
  assign ext_b_word  = {4'h0, ext_b_r}; // [RL2]
  assign temp_word   = {4'h0, temp_r}; // [RL3]
  assign sd_mux_word = {4'h0, sd_mux_r}; // [RL4]
  assign offset_word = {4'h0, offset_r}; // [RL5] [RL7]
  assign dac_word    = dac_r; // [RL8]
  assign raw_word    = {4'h0, raw_r}; // [RL9]
  assign bypass_word = bypass_nxt; // [RL16]
  assign status_word = {14'h0000, irq_status_nxt};
  assign mask_word   = {14'h0000, irq_mask_nxt};

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  always @* begin
    case (addr_idx)
      `IDX_LIMIT_FLAGS:   rd_val = flags_word; // [RL1]
      `IDX_EXT_A_RESULT:  rd_val = ext_a_word; // [RL2]
      `IDX_EXT_B_RESULT:  rd_val = ext_b_word; // [RL2]
      `IDX_TEMP_RESULT:   rd_val = temp_word; // [RL3]
      `IDX_SD_MUX_RESULT: rd_val = sd_mux_word; // [RL4]
      `IDX_CMP_OFFSET:    rd_val = offset_word; // [RL5] [RL7]
      `IDX_DAC_APPLIED:   rd_val = dac_word; // [RL8]
      `IDX_RAW_RESULT:    rd_val = raw_word; // [RL9]
      `IDX_BYPASS_CTRL:   rd_val = bypass_word; // [RL16]
      `IDX_IRQ_STATUS:    rd_val = status_word;
      `IDX_IRQ_MASK:      rd_val = mask_word;
      default:            rd_val = 16'h0000;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata <= {16'h0000, rd_val};
  end

endmodule

// *** diag_adc_result_bypass_asserts.sv ***
// concurrent checks on the ports of the diagnostic adc readback block
`timescale 1ns/1ps
module diag_adc_result_bypass_asserts #(
  parameter RES_W      = 12,
  parameter GND_CYCLES = 4
) (
  input wire             mclk,              // clock
  input wire             sys_rst,           // sync reset
  input wire             hsel,              // select
  input wire [31:0]      haddr,             // address
  input wire [1:0]       htrans,            // transfer type
  input wire             hwrite,            // write
  input wire             hready,            // bus ready
  input wire [31:0]      hrdata,            // read data
  input wire             hreadyout,         // slave ready
  input wire             hresp,             // response
  input wire             gnd_sample,        // ground phase
  input wire             sig_sample,        // signal strobe
  input wire             conv_valid,        // conversion done
  input wire [RES_W-1:0] conv_raw,          // raw result
  input wire             meas_offset_valid, // offset strobe
  input wire [RES_W-1:0] meas_offset,       // offset
  input wire [15:0]      dac_applied        // applied code
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire       rd_req = hsel && hready && htrans[1] && !hwrite;
  reg  [4:0] gnd_len_r;
  // ground phase cycles counted so far, the full length in the cycle after it, else zero
  always @(posedge mclk) begin
    if (sys_rst || !gnd_sample) gnd_len_r <= 5'h00;
    else gnd_len_r <= gnd_len_r + 5'h01;
  end
  flag_rsvd_a: assert property (
    rd_req && haddr == 32'h0000008c |=> hrdata[31:9] == 23'h0 && !hrdata[0])
    else $error("reserved flag bits not zero");
  result_width_a: assert property (
    rd_req && haddr >= 32'h00000090 && haddr <= 32'h0000009c |=> hrdata[31:12] == 20'h0)
    else $error("result upper bits not zero");
  offset_readback_a: assert property (
    meas_offset_valid ##1 (rd_req && haddr == 32'h000000a0)
    |=> hrdata == {20'h0, $past(meas_offset, 2)})
    else $error("offset readback differs from measurement");
  raw_readback_a: assert property (
    conv_valid ##1 (rd_req && haddr == 32'h000000b4) |=> hrdata[11:0] == $past(conv_raw, 2))
    else $error("raw readback differs from conversion");
  dac_readback_a: assert property (
    rd_req && haddr == 32'h000000b0 && $stable(dac_applied) && !$past(sys_rst)
    |=> hrdata == {16'h0, $past(dac_applied, 2)})
    else $error("dac readback differs from applied code");
  gnd_phase_a: assert property (
    $fell(gnd_sample) |-> sig_sample && gnd_len_r == GND_CYCLES)
    else $error("ground phase length or strobe wrong");
  sig_pulse_a: assert property (sig_sample |=> !sig_sample)
    else $error("signal strobe longer than one cycle");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule

bind diag_adc_result_bypass diag_adc_result_bypass_asserts #(
  .RES_W(RES_W), .GND_CYCLES(GND_CYCLES)) chk_i (
  .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .gnd_sample(gnd_sample), .sig_sample(sig_sample), .conv_valid(conv_valid),
  .conv_raw(conv_raw), .meas_offset_valid(meas_offset_valid), .meas_offset(meas_offset),
  .dac_applied(dac_applied));

// *** testbench.sv ***
// self-checking testbench for the diagnostic adc readback block
`timescale 1ns/1ps
`include "diag_adc_defines.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  localparam G = 3;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         conv_start = 1'b0;
  reg         conv_valid = 1'b0;
  reg  [2:0]  conv_channel = 3'h0;
  reg  [11:0] conv_raw = 12'h000;
  reg         meas_offset_valid = 1'b0;
  reg  [11:0] meas_offset = 12'h000;
  reg  [15:0] dac_applied = 16'h0000;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, gnd_sample, sig_sample, irq;
  reg  [31:0] rd;
  int         failures = 0, n_tests = 0, cycles = 0, ng, ns;

  diag_adc_result_bypass #(.GND_CYCLES(G)) diag_adc_result_bypass_i (
    .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start), .gnd_sample(gnd_sample),
    .sig_sample(sig_sample), .conv_valid(conv_valid), .conv_channel(conv_channel),
    .conv_raw(conv_raw), .meas_offset_valid(meas_offset_valid), .meas_offset(meas_offset),
    .dac_applied(dac_applied), .lo_thresholds({8{12'h100}}),
    .hi_thresholds({12'he00, 12'h4e0, {6{12'he00}}}), // channel 6 has a tighter high limit
    .irq(irq));

  always #25 mclk = ~mclk;
  // ---------------------------------------------------------------
  // bus and stimulus tasks
  // ---------------------------------------------------------------
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test;
    end
  end
  task ahb(input bit wr, input [7:0] idx, input [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {22'h0, idx, 2'b00};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wr ? wd : 32'h0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rdc(input [7:0] idx, input [31:0] e);
    ahb(1'b0, idx, 32'h0);
    `CHK(rd, e)
  endtask
  task irqc(input e);
    #1;
    `CHK(irq, e)
  endtask
  task conv(input [2:0] ch, input [11:0] raw);
    @(posedge mclk);
    conv_valid <= 1'b1; conv_channel <= ch; conv_raw <= raw;
    @(posedge mclk);
    conv_valid <= 1'b0;
  endtask
  task seq_count;
    @(posedge mclk); conv_start <= 1'b1;
    @(posedge mclk); conv_start <= 1'b0;
    ng = 0; ns = 0;
    repeat (G + 4) begin
      #1; ng += gnd_sample; ns += sig_sample;
      @(posedge mclk);
    end
  endtask
  // a strobe on channel 0 or the offset, read back in the very next cycle
  task strobe_rd(input bit cv, input [11:0] v, input [7:0] idx, input [31:0] e);
    fork
      begin
        @(posedge mclk);
        if (cv) begin
          conv_valid <= 1'b1;
          conv_channel <= 3'h0;
          conv_raw <= v;
        end else begin
          meas_offset_valid <= 1'b1;
          meas_offset <= v;
        end
        @(posedge mclk);
        conv_valid <= 1'b0;
        meas_offset_valid <= 1'b0;
      end
      begin
        @(posedge mclk);
        ahb(1'b0, idx, 32'h0);
      end
    join
    `CHK(rd, e)
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    for (int i = 8'h20; i <= 8'h31; i++) rdc(i[7:0], 32'h0);
    irqc(1'b0);
    $display("test reset finished");
  endtask
  task t_regs;
    ahb(1'b1, `IDX_BYPASS_CTRL, 32'hffffffff);
    rdc(`IDX_BYPASS_CTRL, 32'h0000efff);
    ahb(1'b1, `IDX_BYPASS_CTRL, 32'h0);
    ahb(1'b1, `IDX_LIMIT_FLAGS, 32'hffff);
    rdc(`IDX_LIMIT_FLAGS, 32'h0);
    $display("test registers finished");
  endtask
  task t_results;
    strobe_rd(1'b0, 12'h010, `IDX_CMP_OFFSET, 32'h010);
    strobe_rd(1'b1, 12'h050, `IDX_RAW_RESULT, 32'h050);
    conv(3'h1, 12'h810);
    conv(3'h2, 12'hf10);
    for (int c = 3; c < 8; c++) conv(c[2:0], c == 7 ? 12'h008 : 12'h500);
    rdc(`IDX_EXT_A_RESULT, 32'h040);
    rdc(`IDX_EXT_B_RESULT, 32'h800);
    rdc(`IDX_TEMP_RESULT, 32'hf00);
    rdc(`IDX_SD_MUX_RESULT, 32'h000);
    rdc(`IDX_RAW_RESULT, 32'h008);
    rdc(`IDX_LIMIT_FLAGS, 32'h18a);
    rdc(`IDX_CMP_OFFSET, 32'h010);
    $display("test results finished");
  endtask
  task t_overrides;
    ahb(1'b1, `IDX_BYPASS_CTRL, 32'h4ff0);
    conv(3'h0, 12'h100);
    rdc(`IDX_EXT_A_RESULT, 32'h110);
    rdc(`IDX_LIMIT_FLAGS, 32'h188);
    rdc(`IDX_CMP_OFFSET, 32'h010);
    rdc(`IDX_RAW_RESULT, 32'h100);
    ahb(1'b1, `IDX_BYPASS_CTRL, 32'hc050);
    conv(3'h1, 12'h700);
    rdc(`IDX_EXT_B_RESULT, 32'h050);
    rdc(`IDX_LIMIT_FLAGS, 32'h18c);
    rdc(`IDX_RAW_RESULT, 32'h700);
    rdc(`IDX_CMP_OFFSET, 32'h010);
    $display("test overrides finished");
  endtask
  task t_ground;
    ahb(1'b1, `IDX_BYPASS_CTRL, 32'h0);
    seq_count;
    `CHK(ng, G)
    `CHK(ns, 1)
    ahb(1'b1, `IDX_BYPASS_CTRL, 32'h2000);
    seq_count;
    `CHK(ng, 0)
    `CHK(ns, 1)
    $display("test ground sampling finished");
  endtask
  task t_irq;
    rdc(`IDX_IRQ_STATUS, 32'h3);
    irqc(1'b0);
    ahb(1'b1, `IDX_IRQ_MASK, 32'h1);
    irqc(1'b1);
    ahb(1'b1, `IDX_IRQ_STATUS, 32'h1);
    irqc(1'b0);
    rdc(`IDX_IRQ_STATUS, 32'h2);
    ahb(1'b1, `IDX_IRQ_MASK, 32'h3);
    irqc(1'b1);
    ahb(1'b1, `IDX_IRQ_STATUS, 32'h2);
    irqc(1'b0);
    rdc(`IDX_IRQ_STATUS, 32'h0);
    $display("test interrupt finished");
  endtask
  task t_dac;
    @(posedge mclk); dac_applied <= 16'ha5c3;
    rdc(`IDX_DAC_APPLIED, 32'ha5c3);
    $display("test dac readback finished");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_regs;
    t_results;
    t_overrides;
    t_ground;
    t_irq;
    t_dac;
    stop_test;
  end
endmodule
